// ---- rtl/adc_defs.svh ----
// offsets, field positions, reset values and timing counts of the adc block
// assumes inclusion by bare name from the prescaler, device, cpu end and bench files
`ifndef ADC_DEFS_SVH
`define ADC_DEFS_SVH

// module register indices
`define REG_CTRL 4'h0
`define REG_CFG_FIRST_BASE 4'h1
`define REG_CFG_SECOND_BASE 4'h2
`define REG_RESULT_BASE 4'h7
`define REG_COUNT 10

// control word fields
`define CTRL_CONV_LSB 0
`define CTRL_POWER_BIT 3
`define CTRL_SE_LSB 4
`define CTRL_RESET 16'h0000

// first configuration register fields
`define CFG1_RES_LSB 0
`define CFG1_GAIN_LSB 3
`define CFG1_REF_LSB 7
`define CFG1_DIV_LSB 9
`define CFG1_RESET 16'h0000

// second configuration register fields
`define CFG2_BIAS_LSB 0
`define CFG2_CO_LSB 8
`define CFG2_RESET 16'h0000
`define RESULT_RESET 16'h0000

// gain handling
`define GAIN_CODE_094 4'h0
`define SE_FIX094_LO 4'h9
`define SE_FIX094_HI 4'hb
`define SE_FIX070_LO 4'hc
`define SE_FIX070_HI 4'hf

// conversion timing
`define RES_MIN_BITS 9
`define RES_MAX_BITS 16
`define CONV_TICKS_BASE 16
`define PRESCALE_MIN 4
`define PRESCALE_MAX 512

// reset hold time
`define CLK_PERIOD_PS 4000
`define RESET_HOLD_US 250
`define RESET_HOLD_CYCLES \
    ((`RESET_HOLD_US * 1000000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)

// cpu side port selects and commands
`define PORT_D 2'h0
`define PORT_E 2'h1
`define PORT_F 2'h2
`define CMD_WRITE 16'h0001
`define CMD_READ 16'h0002

`endif

// ---- rtl/adc_pkg.sv ----
// types shared by both ends of the adc module port
// assumes nothing of its surroundings
package adc_pkg;

    typedef enum logic [1:0] {
        REF_VDD = 2'h0,
        REF_PIN = 2'h1,
        REF_BG_X4 = 2'h2,
        REF_BG = 2'h3
    } ref_sel_t;

    typedef enum logic [1:0] {
        GAIN_PROG = 2'h0,
        GAIN_FIX_094 = 2'h1,
        GAIN_FIX_070 = 2'h2
    } gain_mode_t;

    typedef enum logic [1:0] {
        CH_ONE = 2'h0,
        CH_TWO = 2'h1,
        CH_TEMP = 2'h2,
        CH_NONE = 2'h3
    } chan_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_CONV = 3'b010,
        ST_LATCH = 3'b100
    } conv_state_t;

endpackage

// ---- rtl/adc_port_if.sv ----
// module access carrier between the cpu end and the adc device end
// assumes both ends run on the same clock
`timescale 1ns/1ps
interface adc_port_if;
    logic [3:0] mod_addr;
    logic [15:0] mod_wdata;
    logic mod_wr;
    logic mod_rd;
    logic [15:0] mod_rdata;
    logic cpu_enable;

    modport device (
        input mod_addr,
        input mod_wdata,
        input mod_wr,
        input mod_rd,
        output mod_rdata,
        output cpu_enable
    );

    modport cpu (
        output mod_addr,
        output mod_wdata,
        output mod_wr,
        output mod_rd,
        input mod_rdata,
        input cpu_enable
    );
endinterface

// ---- rtl/adc_prescaler.sv ----
// converter clock prescaler: one tick every 4 << code system clocks
// assumes code is stable while run is high
`timescale 1ns/1ps
`include "adc_defs.svh"
module adc_prescaler #(
    parameter int DIV_W = 9
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic resetn_i,
    // control
    input wire logic run_i,
    input wire logic [2:0] code_i,
    // tick out
    output logic tick_o
);
    if ((`PRESCALE_MIN << 7) > (1 << DIV_W)) begin : g_bad_div
        $error("prescaler counter too narrow");
    end

    logic [DIV_W-1:0] cnt_r;
    logic [DIV_W-1:0] last;

    // divisor 4 .. 512
    assign last = DIV_W'((`PRESCALE_MIN << code_i) - 1);
    assign tick_o = run_i && (cnt_r == last);

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cnt_r <= '0;
        end else if (!run_i || cnt_r == last) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_r + 1'b1;
        end
    end
endmodule

// ---- rtl/adc_device.sv ----
// adc conversion control: register file, conversion sequencer, cpu halt
// assumes an analog front end on the same clock presenting result_i
`timescale 1ns/1ps
`include "adc_defs.svh"
// Function
// - one convert bit written starts conversion
// - cpu halted for whole conversion
// - completion clears all convert bits
// - result latched into converted channel register
// - cpu re-enabled after store and clear
// - ten registers: control, configs, results
// - resolution 9..16 bits, 16-bit two's-complement
// - temperature always uses bandgap reference
// - others select supply, pin, bandgap x4
// - offset converter shares active reference
// - control word picks channel and input
// - single-ended via channel one/two select
// - mux: external pairs plus internal nodes
// - some single-ended inputs force fixed gain
// - gain code in first config register
// - temperature channel fixed gain 0.94
// - software sets gain before starting
// - hold cpu in reset 250us
// - power bit off after reset
// - cpu reaches registers via module ports
// - prescaler divisor 4 to 512
module adc_device
    import adc_pkg::*;
#(
    parameter int RESET_HOLD = `RESET_HOLD_CYCLES,
    parameter int TICK_W = 12
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic resetn_i,
    // module port side
    adc_port_if.device bus,
    // analog front end
    input wire logic [15:0] result_i,
    output logic power_on_o,
    output logic converting_o,
    output logic conv_tick_o,
    output chan_t chan_o,
    output logic [3:0] mux_sel_o,
    output ref_sel_t ref_sel_o,
    output ref_sel_t co_ref_sel_o,
    output gain_mode_t gain_mode_o,
    output logic [3:0] gain_code_o,
    output logic [2:0] resolution_o,
    output logic [2:0] bias_o,
    output logic [7:0] coarse_offset_o,
    output logic cpu_reset_o
);
    if (RESET_HOLD < 1 || RESET_HOLD > (1 << 18)) begin : g_bad_hold
        $error("reset hold out of counter range");
    end
    if ((`CONV_TICKS_BASE << 7) > (1 << TICK_W)) begin : g_bad_tick
        $error("tick counter too narrow");
    end

    logic [15:0] ctrl_r;
    logic [15:0] cfg_first_r [3];
    logic [15:0] cfg_second_r [3];
    logic [15:0] result_r [3];
    logic [15:0] rdata_r;
    conv_state_t state_r;
    chan_t chan_r;
    logic [TICK_W-1:0] tick_cnt_r;
    logic [17:0] hold_cnt_r;
    logic hold_done_r;

    logic ctrl_wr;
    logic [2:0] conv_bits;
    logic start;
    chan_t start_chan;
    logic [15:0] cfg1;
    logic [15:0] cfg2;
    logic [3:0] se_sel;
    logic [2:0] res;
    logic [TICK_W-1:0] tick_last;
    logic tick;
    logic [15:0] res_mask;

    // module register writes through the port carrier
    assign ctrl_wr = bus.mod_wr && bus.mod_addr == `REG_CTRL;
    assign conv_bits = bus.mod_wdata[`CTRL_CONV_LSB +: 3];
    // a write with any convert bit starts when idle
    assign start = ctrl_wr && state_r == ST_IDLE && conv_bits != 3'h0;

    // fixed priority one, two, temperature
    always_comb begin
        if (conv_bits[0]) begin
            start_chan = CH_ONE;
        end else if (conv_bits[1]) begin
            start_chan = CH_TWO;
        end else if (conv_bits[2]) begin
            start_chan = CH_TEMP;
        end else begin
            start_chan = CH_NONE;
        end
    end

    // control word, power bit off at reset
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ctrl_r <= `CTRL_RESET;
        end else if (state_r == ST_LATCH) begin
            ctrl_r[`CTRL_CONV_LSB +: 3] <= 3'h0;
        end else if (ctrl_wr && state_r == ST_IDLE) begin
            ctrl_r <= bus.mod_wdata;
        end
    end

    // per channel configuration and result registers
    for (genvar n = 0; n < 3; n++) begin : g_chan
        always_ff @(posedge clk_i or negedge resetn_i) begin
            if (!resetn_i) begin
                cfg_first_r[n] <= `CFG1_RESET;
                cfg_second_r[n] <= `CFG2_RESET;
            end else if (bus.mod_wr && state_r == ST_IDLE) begin
                if (bus.mod_addr == 4'(`REG_CFG_FIRST_BASE + 2 * n))
                    cfg_first_r[n] <= bus.mod_wdata;
                if (bus.mod_addr == 4'(`REG_CFG_SECOND_BASE + 2 * n))
                    cfg_second_r[n] <= bus.mod_wdata;
            end
        end

        always_ff @(posedge clk_i or negedge resetn_i) begin
            if (!resetn_i) begin
                result_r[n] <= `RESULT_RESET;
            end else if (state_r == ST_LATCH && chan_r == chan_t'(n)) begin
                result_r[n] <= result_i & res_mask;
            end
        end
    end

    // read data one cycle after the read strobe
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rdata_r <= 16'h0000;
        end else if (bus.mod_rd) begin
            if (bus.mod_addr == `REG_CTRL)
                rdata_r <= ctrl_r;
            else if (bus.mod_addr < `REG_RESULT_BASE && bus.mod_addr[0])
                rdata_r <= cfg_first_r[bus.mod_addr[2:1]];
            else if (bus.mod_addr < `REG_RESULT_BASE)
                rdata_r <= cfg_second_r[2'(bus.mod_addr[2:1] - 2'h1)];
            else if (bus.mod_addr < 4'(`REG_COUNT))
                rdata_r <= result_r[2'(bus.mod_addr - `REG_RESULT_BASE)];
            else
                rdata_r <= 16'h0000;
        end
    end
    assign bus.mod_rdata = rdata_r;

    // active channel settings
    assign cfg1 = (chan_r == CH_NONE) ? 16'h0000 : cfg_first_r[chan_r];
    assign cfg2 = (chan_r == CH_NONE) ? 16'h0000 : cfg_second_r[chan_r];
    assign res = cfg1[`CFG1_RES_LSB +: 3];
    assign tick_last = TICK_W'((`CONV_TICKS_BASE << res) - 1);
    assign res_mask = 16'hffff << (3'h7 - res);

    // conversion sequencer
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_r <= ST_IDLE;
            chan_r <= CH_NONE;
            tick_cnt_r <= '0;
        end else begin
            unique case (state_r)
                ST_IDLE: begin
                    tick_cnt_r <= '0;
                    if (start) begin
                        chan_r <= start_chan;
                        state_r <= ST_CONV;
                    end
                end
                ST_CONV: begin
                    if (tick && tick_cnt_r == tick_last) begin
                        state_r <= ST_LATCH;
                    end else if (tick) begin
                        tick_cnt_r <= tick_cnt_r + 1'b1;
                    end
                end
                ST_LATCH: begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end

    adc_prescaler #(
        .DIV_W(9)
    ) u_prescaler (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .run_i(state_r == ST_CONV),
        .code_i(cfg1[`CFG1_DIV_LSB +: 3]),
        .tick_o(tick)
    );

    // cpu reset hold after power-on
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            hold_cnt_r <= '0;
            hold_done_r <= 1'b0;
        end else if (!hold_done_r) begin
            hold_cnt_r <= hold_cnt_r + 1'b1;
            hold_done_r <= hold_cnt_r == 18'(RESET_HOLD - 1);
        end
    end

    // cpu clock gated off while converting
    assign bus.cpu_enable = hold_done_r && state_r == ST_IDLE;
    assign cpu_reset_o = !hold_done_r;

    // analog steering outputs
    assign power_on_o = ctrl_r[`CTRL_POWER_BIT];
    assign converting_o = state_r != ST_IDLE;
    assign conv_tick_o = tick;
    assign chan_o = chan_r;
    assign se_sel = ctrl_r[`CTRL_SE_LSB +: 4];
    // single-ended only on channels one and two
    assign mux_sel_o = (chan_r == CH_TEMP) ? 4'h0 : se_sel;
    assign resolution_o = res;
    assign bias_o = cfg2[`CFG2_BIAS_LSB +: 3];
    assign coarse_offset_o = cfg2[`CFG2_CO_LSB +: 8];

    // reference selection
    always_comb begin
        if (chan_r == CH_TEMP) begin
            ref_sel_o = REF_BG;
        end else begin
            unique case (cfg1[`CFG1_REF_LSB +: 2])
                2'h0: ref_sel_o = REF_VDD;
                2'h1: ref_sel_o = REF_PIN;
                default: ref_sel_o = REF_BG_X4;
            endcase
        end
    end
    assign co_ref_sel_o = ref_sel_o;

    // gain selection
    always_comb begin
        gain_code_o = cfg1[`CFG1_GAIN_LSB +: 4];
        gain_mode_o = GAIN_PROG;
        if (chan_r == CH_TEMP) begin
            gain_mode_o = GAIN_FIX_094;
            gain_code_o = `GAIN_CODE_094;
        end else if (se_sel >= `SE_FIX070_LO && se_sel <= `SE_FIX070_HI) begin
            gain_mode_o = GAIN_FIX_070;
        end else if (se_sel >= `SE_FIX094_LO && se_sel <= `SE_FIX094_HI) begin
            gain_mode_o = GAIN_FIX_094;
            gain_code_o = `GAIN_CODE_094;
        end
    end
endmodule

// ---- rtl/adc_cpu_end.sv ----
// cpu side end: three module-access ports driven from a plain command port
// assumes the device end on the same carrier and clock
`timescale 1ns/1ps
`include "adc_defs.svh"
module adc_cpu_end
    import adc_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic resetn_i,
    // software command port
    input wire logic [1:0] addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [15:0] rdata_o,
    // status
    output logic cpu_running_o,
    // module port carrier
    adc_port_if.cpu bus
);
    logic [15:0] port_d_r;
    logic [15:0] port_e_r;
    logic [15:0] rdata_r;
    logic wr_pend_r;
    logic rd_pend_r;
    logic cap_r;
    logic cmd_ok;

    // orders are only executed while the cpu runs
    assign cmd_ok = wr_i && bus.cpu_enable;

    // module_port_d address, module_port_e data
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            port_d_r <= 16'h0000;
        end else if (cmd_ok && addr_i == `PORT_D) begin
            port_d_r <= wdata_i;
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            port_e_r <= 16'h0000;
        end else if (cap_r) begin
            port_e_r <= bus.mod_rdata;
        end else if (cmd_ok && addr_i == `PORT_E) begin
            port_e_r <= wdata_i;
        end
    end

    // module_port_f commands become single strobes
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            wr_pend_r <= 1'b0;
            rd_pend_r <= 1'b0;
            cap_r <= 1'b0;
        end else begin
            wr_pend_r <= cmd_ok && addr_i == `PORT_F && wdata_i == `CMD_WRITE;
            rd_pend_r <= cmd_ok && addr_i == `PORT_F && wdata_i == `CMD_READ;
            cap_r <= rd_pend_r;
        end
    end

    // gain written before start is the software's duty
    assign bus.mod_addr = port_d_r[3:0];
    assign bus.mod_wdata = port_e_r;
    assign bus.mod_wr = wr_pend_r;
    assign bus.mod_rd = rd_pend_r;

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rdata_r <= 16'h0000;
        end else if (rd_i) begin
            unique case (addr_i)
                `PORT_D: rdata_r <= port_d_r;
                `PORT_E: rdata_r <= port_e_r;
                `PORT_F: rdata_r <= {13'h0, cap_r || rd_pend_r,
                                     wr_pend_r, bus.cpu_enable};
                default: rdata_r <= 16'h0000;
            endcase
        end
    end
    assign rdata_o = rdata_r;
    assign cpu_running_o = bus.cpu_enable;
endmodule

// ---- testbench/adc_port_checker.sv ----
// concurrent checks on the module port carrier
// assumes one clock for both ends and short test conversions
`timescale 1ns/1ps
module adc_port_checker (
    // clock and reset
    input wire logic clk_i,
    input wire logic resetn_i,
    // carrier signals
    input wire logic [3:0] mod_addr,
    input wire logic [15:0] mod_wdata,
    input wire logic mod_wr,
    input wire logic mod_rd,
    input wire logic [15:0] mod_rdata,
    input wire logic cpu_enable
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!resetn_i);

    // accepted conversion start
    sequence s_go;
        mod_wr && mod_addr == 4'h0 && mod_wdata[2:0] != 3'h0 && cpu_enable;
    endsequence

    AST_HALT: assert property (s_go |=> !cpu_enable [*8])
        else $error("cpu not halted after start");
    AST_RESUME: assert property (
        s_go |-> ##[40:1000] $rose(cpu_enable))
        else $error("cpu not resumed in time");
    AST_FELL_CAUSE: assert property (
        $fell(cpu_enable) |-> $past(mod_wr && mod_addr == 4'h0))
        else $error("cpu halted without start");
    AST_NO_WR_HALTED: assert property (!cpu_enable |-> !mod_wr)
        else $error("module write while cpu halted");
    AST_CTRL_CLEAR: assert property (
        mod_rd && mod_addr == 4'h0 && cpu_enable
        |=> mod_rdata[2:0] == 3'h0)
        else $error("convert bits left set");
    AST_RDATA_HOLD: assert property (
        !mod_rd |=> $stable(mod_rdata))
        else $error("read data moved without read");
    AST_UNMAPPED: assert property (
        mod_rd && mod_addr >= 4'ha |=> mod_rdata == 16'h0000)
        else $error("unmapped index read nonzero");
    AST_STROBE_EXCL: assert property (!(mod_wr && mod_rd))
        else $error("read and write strobes together");

    cover property (s_go);
    cover property (mod_rd && mod_addr >= 4'ha);
    cover property ($rose(cpu_enable));
endmodule

// ---- testbench/adc_conversion_control_bench.sv ----
// self-checking bench joining the cpu end and the device end
// assumes the carrier interface, package and defines of the design
`timescale 1ns/1ps
`include "adc_defs.svh"
module adc_conversion_control_bench import adc_pkg::*;;
    logic clk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic [1:0] addr_i = 2'h0;
    logic [15:0] wdata_i = 16'h0000;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [15:0] result_i = 16'h0000;
    logic [15:0] rdata_o;
    logic [15:0] got;
    logic cpu_running_o, power_on_o, converting_o, cpu_reset_o;
    logic [3:0] mux_sel_o;
    logic [3:0] gain_code_o;
    logic [2:0] resolution_o, bias_o;
    logic [7:0] coarse_offset_o;
    chan_t chan_o;
    ref_sel_t ref_sel_o, co_ref_sel_o;
    gain_mode_t gain_mode_o;
    int n_errors = 0;
    int compares = 0;
    int cycles = 0;

    typedef struct packed {
        logic [15:0] ctrl;
        logic [15:0] cfg;
        logic [15:0] rin;
        chan_t ch;
        ref_sel_t rs;
        gain_mode_t gm;
    } row_t;
    row_t rows [5] = '{
        '{16'h0009, 16'h0080, 16'h8f3d, CH_ONE, REF_PIN, GAIN_PROG},
        '{16'h00aa, 16'h0131, 16'h7abc, CH_TWO, REF_BG_X4, GAIN_FIX_094},
        '{16'h000c, 16'h0078, 16'hc001, CH_TEMP, REF_BG, GAIN_FIX_094},
        '{16'h00ce, 16'h0040, 16'h1235, CH_TWO, REF_VDD, GAIN_FIX_070},
        '{16'h000f, 16'h0228, 16'h5555, CH_ONE, REF_VDD, GAIN_PROG}
    };

    adc_port_if link ();
    adc_device #(.RESET_HOLD(8)) u_adc_device (
        .clk_i(clk_i), .resetn_i(resetn_i), .bus(link),
        .result_i(result_i), .power_on_o(power_on_o),
        .converting_o(converting_o), .conv_tick_o(), .chan_o(chan_o),
        .mux_sel_o(mux_sel_o), .ref_sel_o(ref_sel_o),
        .co_ref_sel_o(co_ref_sel_o), .gain_mode_o(gain_mode_o),
        .gain_code_o(gain_code_o), .resolution_o(resolution_o),
        .bias_o(bias_o), .coarse_offset_o(coarse_offset_o),
        .cpu_reset_o(cpu_reset_o));
    adc_cpu_end u_adc_cpu_end (
        .clk_i(clk_i), .resetn_i(resetn_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .cpu_running_o(cpu_running_o), .bus(link));
    adc_port_checker u_adc_port_checker (
        .clk_i(clk_i), .resetn_i(resetn_i), .mod_addr(link.mod_addr),
        .mod_wdata(link.mod_wdata), .mod_wr(link.mod_wr),
        .mod_rd(link.mod_rd), .mod_rdata(link.mod_rdata),
        .cpu_enable(link.cpu_enable));

    initial begin
        forever #2 clk_i = ~clk_i;
    end

    task automatic summarize;
        $display("errors %0d, compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            summarize();
        end
    end

    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        compares++;
        if (g !== e) begin
            n_errors++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, g, e);
        end
    endtask

    task automatic put(input logic [1:0] a, input logic [15:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask

    task automatic get(input logic [1:0] a, output logic [15:0] d);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1;
        d = rdata_o;
    endtask

    task automatic reg_wr(input logic [3:0] idx, input logic [15:0] d);
        put(`PORT_D, {12'h000, idx});
        put(`PORT_E, d);
        put(`PORT_F, `CMD_WRITE);
    endtask

    task automatic reg_rd(input logic [3:0] idx, output logic [15:0] d);
        put(`PORT_D, {12'h000, idx});
        put(`PORT_F, `CMD_READ);
        repeat (3) @(posedge clk_i);
        get(`PORT_E, d);
    endtask

    task automatic do_reset;
        resetn_i <= 1'b0;
        repeat (5) @(posedge clk_i);
        resetn_i <= 1'b1;
        repeat (7) @(posedge clk_i);
        #1;
        chk({15'h0, cpu_running_o}, 16'h0000);
        chk({15'h0, cpu_reset_o}, 16'h0001);
        @(posedge clk_i);
        #1;
        chk({15'h0, cpu_running_o}, 16'h0001);
        chk({15'h0, power_on_o}, 16'h0000);
    endtask

    task automatic run_row(input row_t r);
        logic [15:0] g;
        logic [15:0] want;
        logic [15:0] c2;
        logic [3:0] gc;
        int n;
        gc = (r.gm == GAIN_FIX_094) ? 4'h0 : r.cfg[6:3];
        want = r.rin & ~((16'h1 << (3'h7 - r.cfg[2:0])) - 16'h1);
        c2 = {r.ctrl[7:0], 5'h00, ~r.cfg[2:0]};
        reg_wr(4'h1 + {1'b0, r.ch, 1'b0}, r.cfg);
        reg_wr(4'h2 + {1'b0, r.ch, 1'b0}, c2);
        result_i <= r.rin;
        reg_wr(4'h0, r.ctrl);
        n = 0;
        do begin
            @(posedge clk_i);
            #1;
            n++;
        end while (converting_o !== 1'b1 && n < 20);
        chk({15'h0, cpu_running_o}, 16'h0000);
        chk({14'h0, chan_o}, {14'h0, r.ch});
        chk({12'h0, mux_sel_o}, {12'h0, r.ctrl[7:4]});
        chk({14'h0, ref_sel_o}, {14'h0, r.rs});
        chk({14'h0, co_ref_sel_o}, {14'h0, r.rs});
        chk({14'h0, gain_mode_o}, {14'h0, r.gm});
        chk({15'h0, power_on_o}, {15'h0, r.ctrl[3]});
        chk({12'h0, gain_code_o}, {12'h0, gc});
        chk({13'h0, resolution_o}, {13'h0, r.cfg[2:0]});
        chk({13'h0, bias_o}, {13'h0, ~r.cfg[2:0]});
        chk({8'h0, coarse_offset_o}, {8'h0, r.ctrl[7:0]});
        do begin
            @(posedge clk_i);
            #1;
            n++;
        end while (cpu_running_o !== 1'b1 && n < 2000);
        chk({15'h0, cpu_running_o}, 16'h0001);
        reg_rd(4'h7 + {2'h0, r.ch}, g);
        chk(g, want);
        reg_rd(4'h0, g);
        chk({13'h0, g[2:0]}, 16'h0000);
    endtask

    initial begin
        do_reset();
        foreach (rows[i]) begin
            run_row(rows[i]);
        end
        reg_rd(4'hc, got);
        chk(got, 16'h0000);
        reg_wr(4'h0, 16'h0009);
        repeat (10) @(posedge clk_i);
        do_reset();
        reg_rd(4'h0, got);
        chk(got, 16'h0000);
        summarize();
    end
endmodule
